//--- rtl/fts_sram.v
// What this block does
// - Advance/load high at a recognised edge steps the burst counter.
// - Advance/load low at a recognised edge loads a new start address.
// - Inputs are sampled only on edges where clock qualify is low.
// - Selected only with select one low, two high, three low.
// - Output enable is asynchronous; high tristates data and parity pins.
// - Tristate in write data phase, first clock after deselect, deselected.
// - Clock qualify high holds the command pipeline and stretches the cycle; the write buffer still drains.
// - Sleep input high freezes activity, keeps data; default low.
// - Input pin values are captured on the rising edge.
// - Reads drive the addressed word flow-through, no output register.
// - Parity lanes act like data lanes, written per byte select.
// - Burst strap low gives linear order, high gives interleaved.
// - Write enable low at load starts a write, high a read.
// - Active-low byte selects pick the lanes written.
// - Address picks one of 128 K words; low two bits seed counter.
// - Up to four beats per address, wrapping; type held per burst.
`include "fts_map.vh"

module fts_sram #(
   parameter ADDR_W = 17,
   parameter DEPTH  = 131072,
   parameter APB_AW = 12
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire [APB_AW-1:0] paddr,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [31:0]       pwdata,
   output wire [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   input  wire [ADDR_W-1:0] sram_addr,
   input  wire              advance_or_load,
   input  wire              clock_qualify_n,
   input  wire              chip_select_first_n,
   input  wire              chip_select_second,
   input  wire              chip_select_third_n,
   input  wire              write_enable_n,
   input  wire [3:0]        byte_write_select_n,
   input  wire              output_enable_n,
   input  wire              sleep_request,
   input  wire              burst_order,
   input  wire [31:0]       data_in,
   output wire [31:0]       data_out,
   output wire              data_oe,
   input  wire [3:0]        parity_in,
   output wire [3:0]        parity_out,
   output wire              parity_oe,
   output wire              wbuf_ready
);

   localparam WORD_W = 4 * `FTS_LANE_W;

   // Lane merge, used for both buffered entries in the read bypass
   function [WORD_W-1:0] fts_merge;
      input [WORD_W-1:0] base;
      input [WORD_W-1:0] upd;
      input [3:0]        mask;
      integer            i;
      begin
         fts_merge = base;
         for (i = 0; i < 4; i = i + 1) begin
            if (mask[i])
               fts_merge[i*`FTS_LANE_W +: `FTS_LANE_W] =
                  upd[i*`FTS_LANE_W +: `FTS_LANE_W];
         end
      end
   endfunction

   // Burst order decode: interleaved xors the beat, linear adds with wrap
   function [1:0] fts_burst_low;
      input       ilv;
      input [1:0] start;
      input [1:0] beat;
      begin
         if (ilv)
            fts_burst_low = start ^ beat;
         else
            fts_burst_low = start + beat;
      end
   endfunction

   reg                     ctrl_sleep_q;
   reg [31:0]              prdata_q;
   reg                     mode_q;
   reg                     strap_done_q;
   reg [ADDR_W-1:0]        base_q;
   reg [`FTS_BEAT_W-1:0]   beat_q;
   reg                     act_q;
   reg                     prev_act_q;
   reg                     wr_q;
   reg [3:0]               bw_q;

   reg [ADDR_W-1:0]        ent_addr_q [0:1];
   reg [3:0]               ent_mask_q [0:1];
   reg [WORD_W-1:0]        ent_data_q [0:1];
   reg                     wptr_q;
   reg                     rptr_q;
   reg [1:0]               level_q;

   reg [WORD_W-1:0]        mem_q [0:DEPTH-1];

   wire sleep_act = sleep_request | ctrl_sleep_q;
   wire qual      = ~clock_qualify_n & ~sleep_act;
   wire sel_now   = ~chip_select_first_n & chip_select_second
                    & ~chip_select_third_n;

   // Strap is caught by the clock after reset release, never by the reset
   reg                     mode_d;
   reg                     strap_done_d;

   always @* begin
      mode_d       = mode_q;
      strap_done_d = 1'b1;
      if (!strap_done_q)
         mode_d = burst_order;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q       <= 1'b1;
         strap_done_q <= 1'b0;
      end else begin
         mode_q       <= mode_d;
         strap_done_q <= strap_done_d;
      end
   end

   // Burst address: only the low two bits move within a burst
   wire [1:0] low_addr = fts_burst_low(mode_q, base_q[1:0],
                                       beat_q);
   wire [ADDR_W-1:0] cur_addr = {base_q[ADDR_W-1:2], low_addr};

   // Command pipeline; nothing moves on an unqualified edge
   reg [ADDR_W-1:0]        base_d;
   reg [`FTS_BEAT_W-1:0]   beat_d;
   reg                     act_d;
   reg                     prev_act_d;
   reg                     wr_d;
   reg [3:0]               bw_d;

   always @* begin
      base_d     = base_q;
      beat_d     = beat_q;
      act_d      = act_q;
      prev_act_d = prev_act_q;
      wr_d       = wr_q;
      bw_d       = bw_q;
      if (qual) begin
         prev_act_d = act_q;
         bw_d       = ~byte_write_select_n;
         if (!advance_or_load) begin
            base_d = sram_addr;
            beat_d = 2'b00;
            act_d  = sel_now;
            wr_d   = ~write_enable_n;
         end else begin
            // Selects and write enable are ignored while advancing
            beat_d = beat_q + 2'b01;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_q     <= {ADDR_W{1'b0}};
         beat_q     <= 2'b00;
         act_q      <= 1'b0;
         prev_act_q <= 1'b0;
         wr_q       <= 1'b0;
         bw_q       <= 4'h0;
      end else begin
         base_q     <= base_d;
         beat_q     <= beat_d;
         act_q      <= act_d;
         prev_act_q <= prev_act_d;
         wr_q       <= wr_d;
         bw_q       <= bw_d;
      end
   end

   // Write data arrives one qualified edge after its address beat
   wire push      = qual & act_q & wr_q;
   wire fifo_full = (level_q == 2'd2);
   wire fifo_have = (level_q != 2'd0);
   wire pop       = fifo_have & ~sleep_act;
   assign wbuf_ready = ~fifo_full;

   reg [WORD_W-1:0] in_word;
   integer k;
   always @* begin
      in_word = {WORD_W{1'b0}};
      for (k = 0; k < 4; k = k + 1) begin
         in_word[k*`FTS_LANE_W +: `FTS_LANE_W] =
            {parity_in[k], data_in[k*8 +: 8]};
      end
   end

   // A full buffer drops the beat; the drain rate keeps that from happening
   wire push_ok = push & ~fifo_full;

   always @(posedge pclk) begin
      if (push_ok) begin
         ent_addr_q[wptr_q] <= cur_addr;
         ent_mask_q[wptr_q] <= bw_q;
         ent_data_q[wptr_q] <= in_word;
      end
   end

   reg                     wptr_d;
   reg                     rptr_d;
   reg [1:0]               level_d;

   always @* begin
      wptr_d = wptr_q ^ push_ok;
      rptr_d = rptr_q ^ pop;
      case ({push_ok, pop})
         2'b10:   level_d = level_q + 2'd1;
         2'b01:   level_d = level_q - 2'd1;
         default: level_d = level_q;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_q  <= 1'b0;
         rptr_q  <= 1'b0;
         level_q <= 2'd0;
      end else begin
         wptr_q  <= wptr_d;
         rptr_q  <= rptr_d;
         level_q <= level_d;
      end
   end

   // Array write is held off in sleep, so buffered data waits intact
   integer m;
   always @(posedge pclk) begin
      if (pop) begin
         for (m = 0; m < 4; m = m + 1) begin
            if (ent_mask_q[rptr_q][m])
               mem_q[ent_addr_q[rptr_q]][m*`FTS_LANE_W +: `FTS_LANE_W] <=
                  ent_data_q[rptr_q][m*`FTS_LANE_W +: `FTS_LANE_W];
         end
      end
   end

   // Read path bypasses writes still queued, newest entry last
   wire old_hit = fifo_have & (ent_addr_q[rptr_q] == cur_addr);
   wire new_hit = fifo_full & (ent_addr_q[~rptr_q] == cur_addr);
   wire [WORD_W-1:0] arr_word = mem_q[cur_addr];
   wire [WORD_W-1:0] mid_word = fts_merge(arr_word, ent_data_q[rptr_q],
                                          old_hit ? ent_mask_q[rptr_q]
                                                  : 4'h0);
   wire [WORD_W-1:0] rd_word  = fts_merge(mid_word, ent_data_q[~rptr_q],
                                          new_hit ? ent_mask_q[~rptr_q]
                                                  : 4'h0);

   wire first_clk = act_q & ~prev_act_q;
   wire rd_phase  = act_q & ~wr_q & ~first_clk & ~sleep_act;
   wire drive     = rd_phase & ~output_enable_n;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lane
         assign data_out[g*8 +: 8] = rd_phase ?
            rd_word[g*`FTS_LANE_W +: 8] : 8'h00;
         assign parity_out[g] = rd_phase ?
            rd_word[g*`FTS_LANE_W + 8] : 1'b0;
      end
   endgenerate

   assign data_oe   = drive;
   assign parity_oe = drive;

   // APB slave: zero wait states, unmapped offsets answer with an error
   wire apb_setup  = psel & ~penable;
   wire apb_access = psel & penable;
   wire hit_ctrl   = (paddr == `FTS_OFF_CTRL);
   wire hit_status = (paddr == `FTS_OFF_STATUS);
   wire hit_addr   = (paddr == `FTS_OFF_ADDR);
   wire hit_any    = hit_ctrl | hit_status | hit_addr;

   reg [31:0] status_word;
   reg [31:0] rd_mux;
   always @* begin
      status_word = 32'h0000_0000;
      status_word[`FTS_ST_ACTIVE]  = act_q;
      status_word[`FTS_ST_WRITE]   = wr_q;
      status_word[`FTS_ST_ASLEEP]  = sleep_act;
      status_word[`FTS_ST_INTERLV] = mode_q;
      status_word[`FTS_ST_BEAT_LO +: 2]  = low_addr;
      status_word[`FTS_ST_LEVEL_LO +: 2] = level_q;
      status_word[`FTS_ST_WBUF_RDY] = ~fifo_full;
      rd_mux = 32'h0000_0000;
      if (hit_ctrl)
         rd_mux[`FTS_CTRL_SLEEP] = ctrl_sleep_q;
      else if (hit_status)
         rd_mux = status_word;
      else if (hit_addr)
         rd_mux[ADDR_W-1:0] = cur_addr;
   end

   // Read data is caught at setup, so the access phase needs no wait state
   reg                     ctrl_sleep_d;
   reg [31:0]              prdata_d;

   always @* begin
      ctrl_sleep_d = ctrl_sleep_q;
      prdata_d     = prdata_q;
      if (apb_setup && !pwrite)
         prdata_d = rd_mux;
      if (apb_access && pwrite && hit_ctrl)
         ctrl_sleep_d = pwdata[`FTS_CTRL_SLEEP];
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_sleep_q <= `FTS_CTRL_RST;
         prdata_q     <= 32'h0000_0000;
      end else begin
         ctrl_sleep_q <= ctrl_sleep_d;
         prdata_q     <= prdata_d;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = apb_access & ~hit_any;

endmodule // fts_sram

//--- shared/fts_map.vh
`ifndef FTS_MAP_VH
`define FTS_MAP_VH

// APB register byte offsets
`define FTS_OFF_CTRL      12'h000
`define FTS_OFF_STATUS    12'h004
`define FTS_OFF_ADDR      12'h008

// Control register fields and reset value
`define FTS_CTRL_SLEEP    0
`define FTS_CTRL_RST      1'b0

// Status register field positions
`define FTS_ST_ACTIVE     0
`define FTS_ST_WRITE      1
`define FTS_ST_ASLEEP     2
`define FTS_ST_INTERLV    3
`define FTS_ST_BEAT_LO    4
`define FTS_ST_LEVEL_LO   6
`define FTS_ST_WBUF_RDY   8

// Lane geometry: eight data bits plus one parity bit per lane
`define FTS_LANE_W        9
`define FTS_BEAT_W        2

`endif

//--- tb/fts_sram_monitor.sv
module fts_sram_mon (
   input logic        pclk,
   input logic        presetn,
   input logic        advance_or_load,
   input logic        clock_qualify_n,
   input logic        chip_select_first_n,
   input logic        chip_select_second,
   input logic        chip_select_third_n,
   input logic        write_enable_n,
   input logic        output_enable_n,
   input logic        sleep_request,
   input logic [31:0] data_out,
   input logic        data_oe,
   input logic        parity_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   wire run = !clock_qualify_n && !sleep_request;
   wire sel = !chip_select_first_n && chip_select_second
              && !chip_select_third_n;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence ld_rd; run && !advance_or_load && sel && write_enable_n;
   endsequence
   sequence ld_wr; run && !advance_or_load && sel && !write_enable_n;
   endsequence
   sequence ld_off; run && !advance_or_load && !sel; endsequence
   sequence adv; run && advance_or_load; endsequence
   oe_gate_a: assert property (output_enable_n |-> !data_oe)
      else $error("driving with output enable high");
   par_same_a: assert property (parity_oe == data_oe)
      else $error("parity and data enables differ");
   wr_phase_a: assert property (ld_wr |=> !data_oe)
      else $error("driving in write data phase");
   desel_off_a: assert property (ld_off |=> !data_oe)
      else $error("driving while deselected");
   desel_adv_a: assert property (ld_off ##1 adv |=> !data_oe)
      else $error("advance woke a deselected port");
   first_rd_a: assert property (ld_off ##1 ld_rd |=> !data_oe)
      else $error("driving in first clock after deselect");
   rd_drive_a: assert property (ld_rd ##1 adv |=>
      output_enable_n || data_oe) else $error("read beat not driven");
   stall_hold_a: assert property (clock_qualify_n |=>
      $stable(data_out)) else $error("output moved during stall");
   sleep_off_a: assert property (sleep_request [*2] |-> !data_oe)
      else $error("driving while asleep");
endmodule // fts_sram_mon

bind fts_sram fts_sram_mon i_mon (.*);

//--- tb/fts_ctl_model.sv
module fts_ctl_model (
   input  logic        pclk,
   output logic [9:0]  sram_addr = 10'h000,
   output logic        advance_or_load = 1'h0,
   output logic        clock_qualify_n = 1'h0,
   output logic        chip_select_first_n = 1'h1,
   output logic        chip_select_second = 1'h0,
   output logic        chip_select_third_n = 1'h1,
   output logic        write_enable_n = 1'h1,
   output logic [3:0]  byte_write_select_n = 4'hF,
   output logic        sleep_request = 1'h0,
   output logic [31:0] data_in = 32'h0,
   output logic [3:0]  parity_in = 4'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released lanes toggle so stale data never looks valid
   task cmd(input logic adv, input logic [2:0] cs, input logic wr,
      input logic [9:0] a, input logic [3:0] bw, input logic [35:0] d,
      input logic drv);
      @(posedge pclk);
      clock_qualify_n <= 1'h0;
      advance_or_load <= adv;
      {chip_select_first_n, chip_select_second, chip_select_third_n} <= cs;
      write_enable_n <= !wr;
      sram_addr <= a;
      byte_write_select_n <= bw;
      {parity_in, data_in} <= drv ? d : ~{parity_in, data_in};
   endtask
   task pin(input logic q, input logic s);
      @(posedge pclk);
      clock_qualify_n <= q;
      sleep_request <= s;
   endtask
endmodule // fts_ctl_model

//--- tb/tb.sv
`include "fts_map.vh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'h0, presetn = 1'h0, burst_order = 1'h0;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, data_out, data_in, r;
   logic [3:0]  parity_out, parity_in, byte_write_select_n;
   logic [9:0]  sram_addr;
   logic        output_enable_n = 1'h0, e, pready, pslverr, wbuf_ready;
   logic        data_oe, parity_oe, advance_or_load, clock_qualify_n;
   logic        chip_select_first_n, chip_select_second, chip_select_third_n;
   logic        write_enable_n, sleep_request;
   logic [35:0] ex [4] = '{default: 36'h0};
   int          err_total = 0, compares = 0, cyc = 0;
   always #2.5 pclk = ~pclk;
   fts_sram #(.ADDR_W(10), .DEPTH(1024)) i_dut (.*);
   fts_ctl_model i_ctl (.*);
   task chk(input string nm, input logic [35:0] s, input logic [35:0] x);
      compares++;
      if (s !== x) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task rst(input logic m);
      @(posedge pclk);
      presetn <= 1'h0;
      burst_order <= m;
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      repeat (2) @(posedge pclk);
   endtask
   task t_reg();
      apb(1'h0, 12'h00C, 32'h0);
      chk("unmapped", {e, r}, 36'h100000000);
      apb(1'h0, `FTS_OFF_CTRL, 32'h0);
      chk("ctrl_rst", r, `FTS_CTRL_RST);
      i_ctl.pin(1'h0, 1'h1);
      apb(1'h0, `FTS_OFF_STATUS, 32'h0);
      chk("asleep", r[`FTS_ST_ASLEEP], 1'h1);
      chk("order", r[`FTS_ST_INTERLV], burst_order);
      i_ctl.pin(1'h0, 1'h0);
      apb(1'h1, `FTS_OFF_CTRL, 32'h1);
      apb(1'h0, `FTS_OFF_CTRL, 32'h0);
      chk("ctrl_rw", r, 36'h1);
      apb(1'h1, `FTS_OFF_CTRL, 32'h0);
      $display("reg test end");
   endtask
   task t_write(input logic [3:0] bw, input logic [35:0] d);
      logic [35:0] m;
      m = 36'h0;
      for (int i = 0; i < 4; i++)
         if (!bw[i]) m = m | (36'h0FF << 8 * i) | (36'h1 << (32 + i));
      i_ctl.cmd(1'h0, 3'h2, 1'h1, 10'h004, bw, 36'h0, 1'h0);
      for (int k = 0; k < 4; k++) begin
         i_ctl.cmd(k < 3, k < 3 ? 3'h2 : 3'h5, 1'h1, 10'h0, bw, d + k, 1'h1);
         ex[k] = (ex[k] & ~m) | ((d + k) & m);
         #1 chk("wbuf", wbuf_ready, 1'h1);
      end
      $display("write burst end");
   endtask
   task t_read(input logic [1:0] b, input logic ilv);
      logic [1:0] n;
      i_ctl.cmd(1'h0, 3'h2, 1'h0, 10'h004 | b, 4'hF, 36'h0, 1'h0);
      for (int k = 0; k < 4; k++) begin
         i_ctl.cmd(k < 3, k < 3 ? 3'h2 : 3'h5, 1'h0, 10'h0, 4'hF, 36'h0, 1'h0);
         output_enable_n <= (k == 2);
         n = ilv ? b ^ k[1:0] : b + k[1:0];
         // First clock after deselect shows no word
         #1 chk("rdata", {parity_out, data_out},
            k == 0 ? 36'h0 : ex[n]);
         chk("rd_oe", data_oe, k != 0 && k != 2);
         // Stall after beat 2 is taken: the four edges that follow must not advance
         if (k == 1) i_ctl.pin(1'h1, 1'h0);
         if (k == 1) repeat (3) @(posedge pclk);
      end
      $display("read burst end");
   endtask
   task t_desel();
      for (int c = 0; c < 8; c++) begin
         if (c == 2) continue;
         i_ctl.cmd(1'h0, c[2:0], 1'h0, 10'h004, 4'hF, 36'h0, 1'h0);
         i_ctl.cmd(1'h1, 3'h2, 1'h0, 10'h004, 4'hF, 36'h0, 1'h0);
         #1 chk("desel", data_oe, 1'h0);
         i_ctl.cmd(1'h0, 3'h2, 1'h0, 10'h004, 4'hF, 36'h0, 1'h0);
         #1 chk("adv_off", data_oe, 1'h0);
      end
      i_ctl.cmd(1'h0, 3'h5, 1'h0, 10'h004, 4'hF, 36'h0, 1'h0);
      $display("deselect test end");
   endtask
   task test_done();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         test_done();
      end
   end
   initial begin
      rst(1'h0);
      t_reg();
      t_write(4'h0, 36'h912345670);
      t_read(2'h1, 1'h0);
      t_write(4'hA, 36'h6ABCDEF00);
      t_desel();
      t_read(2'h2, 1'h0);
      rst(1'h1);
      t_reg();
      t_read(2'h1, 1'h1);
      test_done();
   end
endmodule // tb
